/* File: hdl/mbpb_pkg.sv */
/*
  Constants for the memory bus arbiter and peripheral bridge: channel
  indices, target decode, frame decode, wait states, bridge states.
  Assumes one processor clock and an asynchronous active-high reset.
*/
package mbpb_pkg;
  localparam int N_CH = 6;
  localparam int N_MEM = 2;
  localparam int CH_DW = 0;
  localparam int CH_PW = 1;
  localparam int CH_DR = 2;
  localparam int CH_PRD = 3;
  localparam int CH_FE = 4;
  localparam int CH_DMA = 5;
  localparam int PG_AW = 22;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int PER_AW = 16;
  localparam logic [1:0] T_MEM0 = 2'h0;
  localparam logic [1:0] T_MEM1 = 2'h1;
  localparam logic [1:0] T_PER = 2'h2;
  localparam int MEM_BANK_BIT = 16;
  localparam logic [15:0] PER_HI = 16'h0000;
  localparam logic [3:0] PF1_NIB = 4'h8;
  localparam logic [3:0] PF2_NIB = 4'h9;
  localparam logic [3:0] PF3_NIB = 4'hA;
  localparam logic [1:0] RD_WAIT = 2'h2;
  localparam logic [1:0] SLOT_RB = 2'h0;
  localparam logic [1:0] SLOT_PG = 2'h1;
  localparam logic [1:0] SLOT_DMA = 2'h2;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_GAP = 3'b010,
    PS_ACC = 3'b100
  } mbpb_pstate_t;
  localparam mbpb_pstate_t PS_RESET = PS_IDLE;
endpackage

/* File: hdl/mbpb_bridge.sv */
/*
  Memory bus arbiter with peripheral bridge: five core channels and one
  DMA channel arbitrated per target over two memory banks and one
  peripheral bus with three frame types.
  Assumes requesters hold request, address and data until their ack, and
  targets run on the same clock; memory returns read data one cycle after
  its enable.
*/
`timescale 1ns/10ps
module mbpb_bridge (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data write bus (data and program writes)
  input wire logic dw_req,
  input wire logic pw_req,
  input wire logic [mbpb_pkg::AW-1:0] wb_addr,
  input wire logic [mbpb_pkg::DW-1:0] wb_wdata,
  input wire logic wb_sz32,
  output logic dw_ack,
  output logic pw_ack,
  // data read bus
  input wire logic dr_req,
  input wire logic [mbpb_pkg::AW-1:0] rb_addr,
  input wire logic rb_sz32,
  output logic dr_ack,
  output logic [mbpb_pkg::DW-1:0] rb_rdata,
  // program read bus (program reads and fetches)
  input wire logic prd_req,
  input wire logic fe_req,
  input wire logic [mbpb_pkg::PG_AW-1:0] pg_addr,
  output logic prd_ack,
  output logic fe_ack,
  output logic [mbpb_pkg::DW-1:0] pg_rdata,
  // dma engine
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic dma_sz32,
  input wire logic [mbpb_pkg::AW-1:0] dma_addr,
  input wire logic [mbpb_pkg::DW-1:0] dma_wdata,
  output logic dma_ack,
  output logic [mbpb_pkg::DW-1:0] dma_rdata,
  // memory banks
  output logic [mbpb_pkg::N_MEM-1:0] mem_en,
  output logic [mbpb_pkg::N_MEM-1:0] mem_we,
  output logic [mbpb_pkg::N_MEM-1:0][mbpb_pkg::AW-1:0] mem_addr,
  output logic [mbpb_pkg::N_MEM-1:0][mbpb_pkg::DW-1:0] mem_wdata,
  input wire logic [mbpb_pkg::N_MEM-1:0][mbpb_pkg::DW-1:0] mem_rdata,
  // peripheral bus
  output logic per_strobe,
  output logic per_we,
  output logic per_sz32,
  output logic [2:0] per_frame,
  output logic [mbpb_pkg::PER_AW-1:0] per_addr,
  output logic [mbpb_pkg::DW-1:0] per_wdata,
  input wire logic [mbpb_pkg::DW-1:0] per_rdata,
  input wire logic per_ready
);
  import mbpb_pkg::*;

  typedef struct packed {
    logic [N_CH-1:0] busy;
    logic [N_CH-1:0] ack;
    logic [2:0][DW-1:0] rdata;
    logic [N_MEM-1:0] mem_en;
    logic [N_MEM-1:0] mem_we;
    logic [N_MEM-1:0][AW-1:0] mem_addr;
    logic [N_MEM-1:0][DW-1:0] mem_wdata;
    logic [N_MEM-1:0][2:0] mem_own;
    logic [N_MEM-1:0] ret;
    logic [N_MEM-1:0] ret_we;
    logic [N_MEM-1:0][2:0] ret_own;
    logic [N_MEM:0] conf;
    mbpb_pstate_t ps;
    logic [2:0] per_own;
    logic per_strobe;
    logic per_we;
    logic per_sz32;
    logic per_f1w;
    logic [2:0] per_frame;
    logic [PER_AW-1:0] per_addr;
    logic [DW-1:0] per_wdata;
    logic [1:0] per_cnt;
  } mbpb_state_t;

  mbpb_state_t s_q;
  mbpb_state_t s_d;
  logic [N_CH-1:0] ch_req;
  logic [N_CH-1:0] ch_wr;
  logic [N_CH-1:0] ch_sz32;
  logic [N_CH-1:0][AW-1:0] ch_addr;
  logic [N_CH-1:0][DW-1:0] ch_wdata;

  // target of an address: peripheral frame or memory bank
  function automatic logic [2:0] frame_of(input logic [AW-1:0] a);
    logic [2:0] f;
    f = 3'h0;
    if (a[31:16] == PER_HI) begin
      if (a[15:12] == PF1_NIB) f = 3'h1;
      if (a[15:12] == PF2_NIB) f = 3'h2;
      if (a[15:12] == PF3_NIB) f = 3'h4;
    end
    return f;
  endfunction

  function automatic logic [1:0] tgt_of(input logic [AW-1:0] a);
    logic [1:0] t;
    t = a[MEM_BANK_BIT] ? T_MEM1 : T_MEM0;
    if (frame_of(a) != 3'h0) t = T_PER;
    return t;
  endfunction

  // read data slot of a channel
  function automatic logic [1:0] slot_of(input logic [2:0] c);
    logic [1:0] r;
    r = SLOT_RB;
    if (c == 3'(CH_PRD) || c == 3'(CH_FE)) r = SLOT_PG;
    if (c == 3'(CH_DMA)) r = SLOT_DMA;
    return r;
  endfunction

  // fixed priority pick, lowest index wins; bit 3 is found
  function automatic logic [3:0] pick(input logic [N_CH-1:0] c);
    logic [3:0] r;
    r = 4'h0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (c[i]) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // channel gathering; program buses carry 22-bit addresses
  assign ch_req = {dma_req, fe_req, prd_req, dr_req, pw_req, dw_req};
  assign ch_wr = {dma_we, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  assign ch_sz32 = {dma_sz32, 1'b1, 1'b1, rb_sz32, wb_sz32, wb_sz32};
  assign ch_addr[CH_DW] = wb_addr;
  assign ch_addr[CH_PW] = {10'h000, wb_addr[PG_AW-1:0]};
  assign ch_addr[CH_DR] = rb_addr;
  assign ch_addr[CH_PRD] = {10'h000, pg_addr};
  assign ch_addr[CH_FE] = {10'h000, pg_addr};
  assign ch_addr[CH_DMA] = dma_addr;
  assign ch_wdata[CH_DW] = wb_wdata;
  assign ch_wdata[CH_PW] = wb_wdata;
  assign ch_wdata[CH_DR] = 32'h0000_0000;
  assign ch_wdata[CH_PRD] = 32'h0000_0000;
  assign ch_wdata[CH_FE] = 32'h0000_0000;
  assign ch_wdata[CH_DMA] = dma_wdata;

  always_comb begin
    logic [N_CH-1:0] elig;
    logic [N_CH-1:0] cand;
    logic [3:0] w;
    logic [2:0] f;
    logic done;
    elig = '0;
    cand = '0;
    w = 4'h0;
    f = 3'h0;
    done = 1'b0;
    s_d = s_q;
    s_d.ack = '0;
    s_d.mem_en = '0;
    s_d.ret = s_q.mem_en;
    s_d.ret_we = s_q.mem_we;
    s_d.ret_own = s_q.mem_own;
    // memory returns, one cycle after enable
    for (int b = 0; b < N_MEM; b++) begin
      if (s_q.ret[b]) begin
        s_d.ack[s_q.ret_own[b]] = 1'b1;
        s_d.busy[s_q.ret_own[b]] = 1'b0;
        if (!s_q.ret_we[b]) s_d.rdata[slot_of(s_q.ret_own[b])] = mem_rdata[b];
      end
    end
    // requests not yet served stay eligible every cycle
    elig = ch_req & ~s_q.busy & ~s_q.ack;
    // each memory bank arbitrates on its own
    for (int b = 0; b < N_MEM; b++) begin
      for (int i = 0; i < N_CH; i++) begin
        cand[i] = elig[i] && tgt_of(ch_addr[i]) == 2'(b);
      end
      w = pick(cand);
      if (|cand[N_CH-2:0] && cand[CH_DMA] && !s_q.conf[b]) begin
        s_d.conf[b] = 1'b1;
      end else if (w[3]) begin
        s_d.conf[b] = 1'b0;
        s_d.busy[w[2:0]] = 1'b1;
        s_d.mem_en[b] = 1'b1;
        s_d.mem_we[b] = ch_wr[w[2:0]];
        s_d.mem_addr[b] = ch_addr[w[2:0]];
        s_d.mem_wdata[b] = ch_wdata[w[2:0]];
        s_d.mem_own[b] = w[2:0];
      end
    end
    // peripheral bridge arbitration, only when the bus is idle
    for (int i = 0; i < N_CH; i++) begin
      cand[i] = elig[i] && tgt_of(ch_addr[i]) == T_PER;
    end
    w = pick(cand);
    if (s_q.ps == PS_IDLE) begin
      if (|cand[N_CH-2:0] && cand[CH_DMA] && !s_q.conf[N_MEM]) begin
        s_d.conf[N_MEM] = 1'b1;
      end else if (w[3]) begin
        s_d.conf[N_MEM] = 1'b0;
        f = frame_of(ch_addr[w[2:0]]);
        if ((f[1] && ch_sz32[w[2:0]]) || (w[2:0] == 3'(CH_DMA) && !f[2])) begin
          // refused access: answered at once, no bus cycle
          s_d.ack[w[2:0]] = 1'b1;
          if (!ch_wr[w[2:0]]) s_d.rdata[slot_of(w[2:0])] = 32'h0000_0000;
        end else begin
          s_d.busy[w[2:0]] = 1'b1;
          s_d.per_own = w[2:0];
          s_d.per_we = ch_wr[w[2:0]];
          s_d.per_sz32 = ch_sz32[w[2:0]];
          s_d.per_frame = f;
          s_d.per_addr = ch_addr[w[2:0]][PER_AW-1:0];
          s_d.per_wdata = ch_wdata[w[2:0]];
          s_d.per_cnt = 2'h0;
          s_d.per_f1w = 1'b0;
          if (f[0] && ch_wr[w[2:0]] && s_q.per_f1w) begin
            s_d.ps = PS_GAP;
          end else begin
            s_d.ps = PS_ACC;
            s_d.per_strobe = 1'b1;
          end
        end
      end
    end
    // peripheral transfer sequencing
    case (s_q.ps)
      PS_IDLE: begin
      end
      PS_GAP: begin
        s_d.ps = PS_ACC;
        s_d.per_strobe = 1'b1;
      end
      PS_ACC: begin
        if (s_q.per_frame[1]) begin
          done = s_q.per_we || s_q.per_cnt == RD_WAIT;
        end else begin
          done = per_ready && (s_q.per_we || s_q.per_cnt == RD_WAIT);
        end
        if (s_q.per_cnt != RD_WAIT) s_d.per_cnt = s_q.per_cnt + 2'h1;
        if (done) begin
          s_d.ps = PS_IDLE;
          s_d.per_strobe = 1'b0;
          s_d.ack[s_q.per_own] = 1'b1;
          s_d.busy[s_q.per_own] = 1'b0;
          s_d.per_f1w = s_q.per_frame[0] && s_q.per_we;
          if (!s_q.per_we) begin
            s_d.rdata[slot_of(s_q.per_own)] = s_q.per_sz32 ? per_rdata :
                                              {16'h0000, per_rdata[15:0]};
          end
        end
      end
      default: begin
        s_d.ps = PS_IDLE;
        s_d.per_strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ps <= PS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign dw_ack = s_q.ack[CH_DW];
  assign pw_ack = s_q.ack[CH_PW];
  assign dr_ack = s_q.ack[CH_DR];
  assign prd_ack = s_q.ack[CH_PRD];
  assign fe_ack = s_q.ack[CH_FE];
  assign dma_ack = s_q.ack[CH_DMA];
  assign rb_rdata = s_q.rdata[SLOT_RB];
  assign pg_rdata = s_q.rdata[SLOT_PG];
  assign dma_rdata = s_q.rdata[SLOT_DMA];
  assign mem_en = s_q.mem_en;
  assign mem_we = s_q.mem_we;
  assign mem_addr = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign per_strobe = s_q.per_strobe;
  assign per_we = s_q.per_we;
  assign per_sz32 = s_q.per_sz32;
  assign per_frame = s_q.per_frame;
  assign per_addr = s_q.per_addr;
  assign per_wdata = s_q.per_wdata;
endmodule

/* File: test/mbpb_bridge_monitor.sv */
/*
  port checker for the bridge.
  bound to every mbpb_bridge; one clock, async high reset.
*/
`timescale 1ns/10ps
module mbpb_bridge_monitor (
  // clock, reset
  input wire logic clk,
  input wire logic rst,
  // answers
  input wire logic dw_ack,
  input wire logic pw_ack,
  input wire logic dr_ack,
  input wire logic prd_ack,
  input wire logic fe_ack,
  input wire logic dma_ack,
  // memory and peripheral
  input wire logic [1:0] mem_en,
  input wire logic per_strobe,
  input wire logic per_we,
  input wire logic per_sz32,
  input wire logic [2:0] per_frame,
  input wire logic [15:0] per_addr
);
  logic any_ack;
  assign any_ack = dw_ack | pw_ack | dr_ack | prd_ack | fe_ack | dma_ack;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_done; $fell(per_strobe) |-> any_ack; endproperty
  a_done: assert property (p_done)
    else $error("strobe ended without ack");
  property p_f2sz; per_strobe && per_frame[1] |-> !per_sz32; endproperty
  a_f2sz: assert property (p_f2sz)
    else $error("wide access on frame two");
  property p_f2rd;
    $rose(per_strobe) && per_frame[1] && !per_we |-> per_strobe[*3] ##1 !per_strobe;
  endproperty
  a_f2rd: assert property (p_f2rd)
    else $error("frame two read length");
  property p_f2wr; $rose(per_strobe) && per_frame[1] && per_we |=> !per_strobe; endproperty
  a_f2wr: assert property (p_f2wr)
    else $error("frame two write length");
  property p_f1rd; $rose(per_strobe) && !per_frame[1] && !per_we |-> per_strobe[*3]; endproperty
  a_f1rd: assert property (p_f1rd)
    else $error("read shorter than two waits");
  property p_hold;
    per_strobe && $past(per_strobe) |-> $stable(per_addr) && $stable(per_frame)
      && $stable(per_we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("peripheral request moved");
  property p_one; per_strobe |-> $onehot(per_frame); endproperty
  a_one: assert property (p_one)
    else $error("frame select not one-hot");
  property p_mem; |mem_en |-> ##2 any_ack; endproperty
  a_mem: assert property (p_mem)
    else $error("memory access not acked");
endmodule
bind mbpb_bridge mbpb_bridge_monitor u_mon (.*);

/* File: test/mbpb_far_model.sv */
/*
  memory banks and peripheral registers at the bridge's far side.
  same clock; ready delay set by the bench.
*/
`timescale 1ns/10ps
module mbpb_far_model (
  // clock, reset
  input wire logic clk,
  input wire logic rst,
  // memory banks
  input wire logic [1:0] mem_en,
  input wire logic [1:0] mem_we,
  input wire logic [1:0][31:0] mem_addr,
  input wire logic [1:0][31:0] mem_wdata,
  output logic [1:0][31:0] mem_rdata,
  // peripheral bus
  input wire logic per_strobe,
  input wire logic [2:0] per_frame,
  input wire logic [15:0] per_addr,
  output logic [31:0] per_rdata,
  output logic per_ready,
  // ready delay in strobe cycles
  input wire logic [31:0] rlat
);
  logic [31:0] m [2][16];
  logic [4:0] cnt_q = '0;
  logic tog_q = 0;
  always @(posedge clk) begin
    tog_q <= ~tog_q;
    cnt_q <= per_strobe ? cnt_q + 5'h1 : 5'h0;
    for (int b = 0; b < 2; b++) begin
      mem_rdata[b] <= rst ? 32'h0 : ~mem_rdata[b];
      if (mem_en[b] && mem_we[b]) m[b][mem_addr[b][3:0]] <= mem_wdata[b];
      if (mem_en[b] && !mem_we[b]) mem_rdata[b] <= m[b][mem_addr[b][3:0]];
    end
  end
  // idle ready toggles, data inverted until ready; frame two never waits on ready
  assign per_ready = per_strobe ? (32'(cnt_q) >= rlat) : tog_q;
  assign per_rdata = (per_ready || (per_strobe && per_frame[1])) ? {per_addr, ~per_addr} :
                     {~per_addr, per_addr};
endmodule

/* File: test/mbpb_bridge_test.sv */
/*
  self-checking bench for the bridge.
  far side from mbpb_far_model; checker bound separately.
*/
`timescale 1ns/10ps
module mbpb_bridge_test;
  import mbpb_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [5:0] req = '0;
  logic [31:0] wb_addr = '0, wb_wdata = '0, rb_addr = '0, dma_addr = '0, dma_wdata = '0;
  logic wb_sz32 = 0, rb_sz32 = 0, dma_sz32 = 0, dma_we = 0, ps_q = 0;
  logic [21:0] pg_addr = '0;
  logic [5:0] ack;
  logic [31:0] rb_rdata, pg_rdata, dma_rdata, per_rdata, per_wdata;
  logic [1:0] mem_en, mem_we;
  logic [1:0][31:0] mem_addr, mem_wdata, mem_rdata;
  logic per_strobe, per_we, per_sz32, per_ready;
  logic [2:0] per_frame;
  logic [15:0] per_addr, pa;
  logic [31:0] pwd;
  logic [1:0] pwe;
  int err_total = 0, n_tests = 0, n_str = 0, rlat = 0, seed = 32'h45cc;
  always #25 clk = ~clk;
  mbpb_bridge dut (.*, .dw_req(req[0]), .pw_req(req[1]), .dr_req(req[2]),
    .prd_req(req[3]), .fe_req(req[4]), .dma_req(req[5]), .dw_ack(ack[0]),
    .pw_ack(ack[1]), .dr_ack(ack[2]), .prd_ack(ack[3]), .fe_ack(ack[4]),
    .dma_ack(ack[5]));
  mbpb_far_model far (.*);
  always @(posedge clk) begin
    ps_q <= per_strobe;
    if (per_strobe && !ps_q) begin
      n_str++;
      pa <= per_addr;
      pwd <= per_wdata;
      pwe <= {per_we, per_sz32};
    end
  end
  function automatic logic [31:0] pd(logic [31:0] a, logic s);
    return s ? {a[15:0], ~a[15:0]} : {16'h0, ~a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // channel 5 dma read, 6 dma write
  task automatic go(input int ch, input logic [31:0] a, d, input logic s, output int n,
      output logic [31:0] r);
    int k;
    k = ch > 5 ? 5 : ch;
    @(posedge clk);
    #2;
    case (ch)
      0, 1: begin wb_addr = a; wb_wdata = d; wb_sz32 = s; end
      2: begin rb_addr = a; rb_sz32 = s; end
      3, 4: pg_addr = a[21:0];
      default: begin dma_addr = a; dma_wdata = d; dma_sz32 = s; dma_we = ch == 6; end
    endcase
    req[k] = 1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (!ack[k] && n < 40);
    r = k == 2 ? rb_rdata : k == 5 ? dma_rdata : pg_rdata;
    #1;
    req[k] = 0;
  endtask
  task automatic t(input int ch, input logic [31:0] a, d, input logic s, input int el,
      input logic [31:0] er);
    int n;
    logic [31:0] r;
    go(ch, a, d, s, n, r);
    chk(n, el, "latency");
    if (ch inside {[2:5]}) chk(r, er, "read data");
  endtask
  initial begin
    int n1, n2, n3, wc, rc, s0;
    logic [31:0] r1, r2, r3, a, d;
    repeat (16) @(posedge clk);
    #2 rst = 0;
    chk(32'({ack, per_strobe, mem_en}), 32'h0, "reset outputs");
    t(0, 32'h9002, 32'h1234, 0, 2, 0);
    t(0, 32'h8004, 32'h5678, 1, 2, 0);
    t(1, 32'h8006, 32'h9ABC, 0, 3, 0);
    rlat = 5;
    t(2, 32'h9008, 0, 0, 4, pd(32'h9008, 0));
    t(2, 32'h800A, 0, 1, 7, pd(32'h800A, 1));
    t(5, 32'hA00C, 0, 1, 7, pd(32'hA00C, 1));
    t(6, 32'hA020, 32'h55AA, 1, 7, 0);
    chk(pwd, 32'h0000_55AA, "peripheral write data");
    chk(32'(pwe), 32'h3, "peripheral write and width");
    rlat = 0;
    t(3, 32'hA00E, 0, 0, 4, pd(32'hA00E, 1));
    chk(32'(pa), 32'h0000_A00E, "peripheral address");
    s0 = n_str;
    t(2, 32'h9010, 0, 1, 1, 0);
    t(5, 32'h8012, 0, 0, 1, 0);
    t(5, 32'h9014, 0, 0, 1, 0);
    chk(n_str - s0, 0, "refused strobes");
    $display("test frames done");
    // one fetch, one read and one write at once, each to its own target: bank 0, bank 1, peripheral
    fork
      go(4, 32'h0001, 0, 0, n1, r1);
      go(2, 32'h10002, 0, 0, n2, r2);
      go(0, 32'h9016, 32'h1, 0, n3, r3);
    join
    chk(n1, 3, "fetch latency");
    chk(n2, 3, "read latency");
    chk(n3, 2, "write latency");
    fork
      go(4, 32'h0003, 0, 0, n1, r1);
      go(2, 32'h0003, 0, 0, n2, r2);
      go(0, 32'h0003, 32'hC0DE, 1, n3, r3);
    join
    chk(32'(n3 < n2 && n2 < n1), 32'h1, "priority order");
    chk(r2, 32'hC0DE, "read after write");
    chk(r1, 32'hC0DE, "held fetch data");
    fork
      go(2, 32'h10003, 0, 0, n1, r1);
      go(5, 32'h10003, 0, 0, n2, r2);
    join
    chk(n1, 4, "conflict latency");
    chk(32'(n2 > n1), 32'h1, "dma after core");
    $display("test arbitration done");
    repeat (12) begin
      a = {15'h0, 1'($random(seed)), 12'h0, 4'($random(seed))};
      d = $random(seed);
      wc = $unsigned($random(seed)) % 3;
      rc = 2 + $unsigned($random(seed)) % 4;
      t(wc == 2 ? 6 : wc, a, d, 1, 3, 0);
      t(rc, a, 0, 1, 3, d);
    end
    $display("test random done");
    end_sim;
  end
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
endmodule
